// [pmwc_pkg.sv]
package pmwc_pkg;
    // ====================================================================
    // register map (one word apart on the bus, byte addresses)
    localparam logic [3:0] ADDR_SCC = 4'h0;
    localparam logic [3:0] ADDR_FAST_OSC_CONTROL_REG = 4'h4;
    localparam logic [3:0] ADDR_WAKE_EN = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;
    localparam logic [4:0] ADDR_EVT_CLR = 5'h10;
    localparam logic [4:0] ADDR_EVT_EN = 5'h14;
    // ====================================================================
    // field positions
    localparam int SCC_CKS_LSB = 5;
    localparam int SCC_FKEEP_BIT = 1;
    localparam int SCC_SKEEP_BIT = 0;
    localparam int FAST_OSC_CONTROL_REG_STABLE_BIT = 1;
    localparam int FAST_OSC_CONTROL_REG_EN_BIT = 0;
    localparam int ST_PDF_BIT = 0;
    localparam int ST_TO_BIT = 1;
    // ====================================================================
    // reset values and slow clock select code
    localparam logic [7:0] SCC_RST = 8'h00;
    localparam logic [7:0] FAST_OSC_CONTROL_REG_RST = 8'h01;
    localparam logic [7:0] WAKE_EN_RST = 8'h00;
    localparam logic [2:0] CKS_SLOW = 3'h7;
    // ====================================================================
    // timing
    localparam int CLK_MHZ = 100;
    localparam int OSC_SETTLE_US = 2;
    localparam int OSC_SETTLE_CYC = OSC_SETTLE_US * CLK_MHZ;
    typedef enum logic [2:0] {
        PMWC_RUN, PMWC_SLEEP, PMWC_NAP_SLOW, PMWC_NAP_BOTH, PMWC_NAP_FAST, PMWC_WAKE
    } pmwc_mode_t;
endpackage

// [pmwc_sync2.sv]
`timescale 1ns/1ps
`default_nettype none
module pmwc_sync2 #(
    parameter int W = 8
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_q;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_q <= '0;
            o_q <= '0;
        end else begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// [pmwc_edge_latch.sv]
`timescale 1ns/1ps
`default_nettype none
// clockless capture: pin falling edge sets a latch while enabled
module pmwc_edge_latch (
    input wire logic i_pin,
    input wire logic i_enable,
    input wire logic i_clear,
    output logic o_hit
);
    // edge on the pin itself, so it works while every clock is stopped
    always_ff @(negedge i_pin or posedge i_clear) begin
        if (i_clear) begin
            o_hit <= 1'b0;
        end else begin
            o_hit <= i_enable;
        end
    end
endmodule
`default_nettype wire

// [pmwc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module pmwc_top #(
    parameter int NPINS = 8,
    parameter int SETTLE_CYC = pmwc_pkg::OSC_SETTLE_CYC
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [31:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    input wire logic i_wb_we,
    input wire logic [3:0] i_wb_sel,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    output logic o_wb_ack,
    input wire logic i_halt,
    input wire logic i_clr_wdt,
    input wire logic i_irq_req,
    input wire logic i_irq_enabled,
    input wire logic i_stack_full,
    input wire logic i_wdt_overflow,
    input wire logic [NPINS-1:0] i_porta,
    output logic o_core_run,
    output logic o_irq_take,
    output logic o_pc_sp_reset,
    output logic o_wdt_clear,
    output logic o_fast_clk_en,
    output logic o_slow_clk_en,
    output logic o_slow_rc_oscillator_en,
    output logic [2:0] o_sys_clk_select,
    output logic o_irq
);
    // ====================================================================
    // bus decode
    logic [7:0] scc_q, fast_osc_control_reg_en_q, wake_en_q;
    logic pdf_q, to_q, stable_q, ack_q;
    logic [31:0] rdat_q;
    logic [1:0] evt_q, evt_en_q;
    wire bus_req = i_wb_cyc && i_wb_stb && !ack_q;
    wire wr = bus_req && i_wb_we && i_wb_sel[0];
    // five address bits: the event registers sit above the 4-bit window
    wire [4:0] adr = i_wb_adr[4:0];
    wire wr_scc = wr && adr == {1'b0, pmwc_pkg::ADDR_SCC};
    wire wr_fast_osc_control_reg = wr && adr == {1'b0, pmwc_pkg::ADDR_FAST_OSC_CONTROL_REG};
    wire wr_wake = wr && adr == {1'b0, pmwc_pkg::ADDR_WAKE_EN};
    wire wr_evt_clr = wr && adr == pmwc_pkg::ADDR_EVT_CLR;
    wire wr_evt_en = wr && adr == pmwc_pkg::ADDR_EVT_EN;
    logic [31:0] rd_mux;
    always_comb begin
        unique case (adr)
            {1'b0, pmwc_pkg::ADDR_SCC}: rd_mux = {24'h00_0000, scc_q};
            {1'b0, pmwc_pkg::ADDR_FAST_OSC_CONTROL_REG}: rd_mux = {30'h0000_0000, stable_q, fast_osc_control_reg_en_q[0]};
            {1'b0, pmwc_pkg::ADDR_WAKE_EN}: rd_mux = {24'h00_0000, wake_en_q};
            {1'b0, pmwc_pkg::ADDR_STATUS}: rd_mux = {28'h000_0000, evt_q, to_q, pdf_q};
            pmwc_pkg::ADDR_EVT_EN: rd_mux = {30'h0000_0000, evt_en_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_req;
            rdat_q <= rd_mux;
        end
    end
    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;
    // ====================================================================
    // mode machine
    pmwc_pkg::pmwc_mode_t mode_q, mode_d;
    logic [15:0] settle_q;
    logic irq_pre_q;
    logic [NPINS-1:0] pin_hit, pin_sync;
    logic sleeping;
    assign sleeping = mode_q != pmwc_pkg::PMWC_RUN && mode_q != pmwc_pkg::PMWC_WAKE;
    // pins captured without a clock; cleared on leaving halt
    genvar g;
    for (g = 0; g < NPINS; g++) begin : g_pin
        pmwc_edge_latch u_lat (
            .i_pin(i_porta[g]),
            .i_enable(wake_en_q[g] && sleeping),
            .i_clear(i_sys_rst || !sleeping),
            .o_hit(pin_hit[g])
        );
    end
    pmwc_sync2 #(.W(NPINS)) u_sync (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_d(pin_hit),
        .o_q(pin_sync)
    );
    wire pin_wake = |pin_sync;
    wire irq_wake = i_irq_req && !irq_pre_q;
    wire any_wake = pin_wake || irq_wake || i_wdt_overflow;
    wire [1:0] keep = {scc_q[pmwc_pkg::SCC_FKEEP_BIT], scc_q[pmwc_pkg::SCC_SKEEP_BIT]};
    wire enter = mode_q == pmwc_pkg::PMWC_RUN && i_halt;
    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            pmwc_pkg::PMWC_RUN: if (i_halt) begin
                unique case (keep)
                    2'b00: mode_d = pmwc_pkg::PMWC_SLEEP;
                    2'b01: mode_d = pmwc_pkg::PMWC_NAP_SLOW;
                    2'b11: mode_d = pmwc_pkg::PMWC_NAP_BOTH;
                    2'b10: mode_d = pmwc_pkg::PMWC_NAP_FAST;
                endcase
            end
            pmwc_pkg::PMWC_WAKE: if (settle_q == 16'h0000) mode_d = pmwc_pkg::PMWC_RUN;
            default: if (any_wake) mode_d = pmwc_pkg::PMWC_WAKE;
        endcase
    end
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mode_q <= pmwc_pkg::PMWC_RUN;
            settle_q <= 16'h0000;
            irq_pre_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            if (enter) irq_pre_q <= i_irq_req;
            if (sleeping && any_wake) settle_q <= 16'(SETTLE_CYC);
            else if (settle_q != 16'h0000) settle_q <= settle_q - 16'h0001;
        end
    end
    // ====================================================================
    // registers, flags, oscillator
    logic [15:0] osc_cnt_q;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            scc_q <= pmwc_pkg::SCC_RST;
            fast_osc_control_reg_en_q <= pmwc_pkg::FAST_OSC_CONTROL_REG_RST;
            wake_en_q <= pmwc_pkg::WAKE_EN_RST;
            pdf_q <= 1'b0;
            to_q <= 1'b0;
            stable_q <= 1'b0;
            osc_cnt_q <= 16'h0000;
            evt_q <= 2'b00;
            evt_en_q <= 2'b00;
        end else begin
            if (wr_scc) scc_q <= i_wb_dat[7:0] & 8'hE3;
            if (wr_fast_osc_control_reg) fast_osc_control_reg_en_q <= {7'h00, i_wb_dat[pmwc_pkg::FAST_OSC_CONTROL_REG_EN_BIT]};
            if (wr_wake) wake_en_q <= i_wb_dat[7:0];
            if (wr_evt_en) evt_en_q <= i_wb_dat[1:0];
            if (enter) pdf_q <= 1'b1;
            else if (i_clr_wdt) pdf_q <= 1'b0;
            if (enter) to_q <= 1'b0;
            else if (sleeping && i_wdt_overflow) to_q <= 1'b1;
            // oscillator restart: flag low until settle count runs out
            if (!o_fast_clk_en) begin
                stable_q <= 1'b0;
                osc_cnt_q <= 16'(SETTLE_CYC);
            end else if (osc_cnt_q != 16'h0000) osc_cnt_q <= osc_cnt_q - 16'h0001;
            else stable_q <= 1'b1;
            // set wins over clear
            evt_q <= (evt_q & ~(wr_evt_clr ? i_wb_dat[1:0] : 2'b00))
                | {sleeping && any_wake, enter};
        end
    end
    // ====================================================================
    // outputs to the core and clock tree
    wire wake_done = mode_q == pmwc_pkg::PMWC_WAKE && settle_q == 16'h0000;
    wire fast_on = (mode_q == pmwc_pkg::PMWC_RUN && scc_q[7:5] != pmwc_pkg::CKS_SLOW)
        || mode_q == pmwc_pkg::PMWC_WAKE
        || mode_q == pmwc_pkg::PMWC_NAP_BOTH || mode_q == pmwc_pkg::PMWC_NAP_FAST
        || (mode_q == pmwc_pkg::PMWC_RUN && fast_osc_control_reg_en_q[0]);
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_core_run <= 1'b1;
            o_irq_take <= 1'b0;
            o_pc_sp_reset <= 1'b0;
            o_wdt_clear <= 1'b0;
            o_fast_clk_en <= 1'b1;
            o_slow_clk_en <= 1'b1;
            o_slow_rc_oscillator_en <= 1'b1;
            o_sys_clk_select <= 3'h0;
            o_irq <= 1'b0;
        end else begin
            o_core_run <= mode_d == pmwc_pkg::PMWC_RUN;
            // pending irq taken only when enabled with stack room
            o_irq_take <= (mode_d == pmwc_pkg::PMWC_RUN) && i_irq_req
                && i_irq_enabled && !i_stack_full;
            o_pc_sp_reset <= sleeping && i_wdt_overflow;
            o_wdt_clear <= enter || i_clr_wdt;
            o_fast_clk_en <= fast_on;
            o_slow_clk_en <= mode_q == pmwc_pkg::PMWC_RUN || mode_q == pmwc_pkg::PMWC_WAKE
                || mode_q == pmwc_pkg::PMWC_NAP_SLOW
                || mode_q == pmwc_pkg::PMWC_NAP_BOTH;
            o_slow_rc_oscillator_en <= 1'b1;
            // slow select only leaves once stable_q is set or the wake settle count has run out (wake_done)
            if (scc_q[7:5] == pmwc_pkg::CKS_SLOW || stable_q || wake_done)
                o_sys_clk_select <= scc_q[7:5];
            o_irq <= |(evt_q & evt_en_q);
        end
    end

    a_pdf_on_entry: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        enter |=> pdf_q && !to_q) else $error("power-down flags wrong after halt");
    a_wdt_cleared: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        enter |=> o_wdt_clear) else $error("watchdog not cleared on halt");
    a_core_stops: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        enter |=> !o_core_run) else $error("core ran after halt");
    a_slow_rc_oscillator_runs: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        ##1 o_slow_rc_oscillator_en) else $error("slow oscillator stopped");
    a_sleep_clocks: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        enter && keep == 2'b00 |=> ##1 !o_fast_clk_en && !o_slow_clk_en)
        else $error("clocks on in sleep");
    a_wdt_wake_to: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        sleeping && i_wdt_overflow |=> to_q && o_pc_sp_reset)
        else $error("watchdog wake flags wrong");
    a_wake_waits: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        mode_q == pmwc_pkg::PMWC_WAKE && settle_q != 16'h0000 |=> !o_core_run)
        else $error("resumed before settle");
    a_clrwdt_pdf: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_clr_wdt && !enter |=> !pdf_q) else $error("clrwdt left pdf set");
endmodule
`default_nettype wire

// [pmwc_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ====================================================================
// core side: instructions issue only while the core runs
module pmwc_core_model (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_core_run,
    input wire logic i_halt_cmd,
    input wire logic i_clrwdt_cmd,
    output logic o_halt,
    output logic o_clr_wdt
);
    // a stopped core cannot execute, so commands are dropped while halted
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_halt <= 1'b0;
            o_clr_wdt <= 1'b0;
        end else begin
            o_halt <= i_halt_cmd & i_core_run;
            o_clr_wdt <= i_clrwdt_cmd & i_core_run;
        end
    end
endmodule
`default_nettype wire

// [test_power_mode_wake_controller.sv]
`timescale 1ns/1ps
`default_nettype none
module test_power_mode_wake_controller;
    localparam int SETTLE = 5;
    localparam logic [31:0] A_CLR = 32'h0000_0010;
    localparam logic [31:0] A_EEN = 32'h0000_0014;
    localparam logic [31:0] A_BAD = 32'h0000_0018;
    localparam logic [31:0] A_ST = 32'h0000_000C;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [31:0] adr = 32'h0000_0000;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0] sel = 4'h0;
    logic we = 1'b0, cyc = 1'b0, stb = 1'b0, halt_cmd = 1'b0, clr_cmd = 1'b0;
    logic irq_req = 1'b0, irq_en = 1'b0, stk_full = 1'b0, wdt_ov = 1'b0;
    logic [7:0] porta = 8'hff;
    logic [31:0] rd, r;
    logic [2:0] csel;
    wire halt, clr_wdt, ack, core_run, irq_take, pcsp, wdtclr, fen, sen, len, irq;
    int n_fail = 0, n_tests = 0, n_clr = 0, n_pcsp = 0, cyc_cnt = 0, n, m;
    pmwc_top #(.NPINS(8), .SETTLE_CYC(SETTLE)) i_pmwc_top (.i_clk(i_clk),
        .i_sys_rst(i_sys_rst), .i_wb_adr(adr), .i_wb_dat(wdat), .o_wb_dat(rd),
        .i_wb_we(we), .i_wb_sel(sel), .i_wb_cyc(cyc), .i_wb_stb(stb), .o_wb_ack(ack),
        .i_halt(halt), .i_clr_wdt(clr_wdt), .i_irq_req(irq_req), .i_irq_enabled(irq_en),
        .i_stack_full(stk_full), .i_wdt_overflow(wdt_ov), .i_porta(porta),
        .o_core_run(core_run), .o_irq_take(irq_take), .o_pc_sp_reset(pcsp),
        .o_wdt_clear(wdtclr), .o_fast_clk_en(fen), .o_slow_clk_en(sen), .o_slow_rc_oscillator_en(len),
        .o_sys_clk_select(csel), .o_irq(irq));
    pmwc_core_model i_pmwc_core_model (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_core_run(core_run), .i_halt_cmd(halt_cmd), .i_clrwdt_cmd(clr_cmd),
        .o_halt(halt), .o_clr_wdt(clr_wdt));
    always #5 i_clk = ~i_clk;
    // ====================================================================
    // pulse counters and hang guard
    always @(posedge i_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (wdtclr === 1'b1) n_clr <= n_clr + 1;
        if (pcsp === 1'b1) n_pcsp <= n_pcsp + 1;
        if (cyc_cnt == 20000) begin
            n_fail = n_fail + 1;
            summarize();
        end
    end
    // ====================================================================
    // tasks
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge i_clk);
    endtask
    // no fixed latency assumed: wait for ack, bounded
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int k;
        k = 0;
        @(posedge i_clk);
        adr <= a;
        wdat <= d;
        we <= w;
        sel <= 4'hf;
        cyc <= 1'b1;
        stb <= 1'b1;
        do begin
            @(posedge i_clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (k >= 20) chk("wb_ack", 1, 0);
    endtask
    task automatic waitc(input int which, input logic [2:0] v, output int c);
        c = 0;
        while (((which == 0) ? {2'b00, core_run} : csel) !== v && c < 200) begin
            @(posedge i_clk);
            c++;
        end
    endtask
    // ====================================================================
    // tests
    initial begin
        tick(10);
        i_sys_rst <= 1'b0;
        wb(0, pmwc_pkg::ADDR_SCC, 0, r);
        chk("scc_rst", pmwc_pkg::SCC_RST, r);
        wb(0, pmwc_pkg::ADDR_FAST_OSC_CONTROL_REG, 0, r);
        chk("osc_en_rst", 1, r[0]);
        wb(0, pmwc_pkg::ADDR_WAKE_EN, 0, r);
        chk("wake_en_rst", pmwc_pkg::WAKE_EN_RST, r);
        wb(0, A_ST, 0, r);
        chk("pdf_rst", 0, r[0]);
        wb(0, A_BAD, 0, r);
        chk("unmapped", 0, r);
        wb(1, pmwc_pkg::ADDR_WAKE_EN, 4, r);
        for (int k = 0; k < 4; k++) begin
            wb(1, pmwc_pkg::ADDR_SCC, k, r);
            m = n_clr;
            if (k == 3) irq_req <= 1'b1;
            halt_cmd <= 1'b1;
            tick(1);
            halt_cmd <= 1'b0;
            waitc(0, 0, n);
            tick(2);
            chk("fast_en", k[1], fen);
            chk("slow_en", k[0], sen);
            chk("slow_rc_oscillator_en", 1, len);
            chk("wdt_clr", m + 1, n_clr);
            wb(0, A_ST, 0, r);
            chk("entry_flags", 1, r[1:0]);
            porta <= 8'hfe;
            tick(20);
            chk("halted", 0, core_run);
            m = n_pcsp;
            irq_en <= 1'b1;
            stk_full <= 1'b1;
            if (k == 1) irq_req <= 1'b1;
            else if (k == 2) wdt_ov <= 1'b1;
            else porta <= 8'hfa;
            tick(1);
            wdt_ov <= 1'b0;
            porta <= 8'hff;
            waitc(0, 1, n);
            chk("settle", 1, n >= SETTLE);
            chk("woken", 1, core_run);
            wb(0, A_ST, 0, r);
            chk("wake_flags", (k == 2) ? 3 : 1, r[1:0]);
            if (k == 2) chk("pcsp", m + 1, n_pcsp);
            if (k == 1) chk("no_take", 0, irq_take);
            stk_full <= 1'b0;
            tick(3);
            if (k == 1) chk("take", 1, irq_take);
            irq_req <= 1'b0;
            irq_en <= 1'b0;
        end
        chk("irq_masked", 0, irq);
        wb(0, A_ST, 0, r);
        chk("events", 3, r[3:2]);
        wb(1, A_EEN, 3, r);
        wb(0, A_EEN, 0, r);
        chk("evt_en", 3, r);
        tick(2);
        chk("irq_on", 1, irq);
        wb(1, A_CLR, 3, r);
        tick(2);
        chk("irq_off", 0, irq);
        wb(0, A_ST, 0, r);
        chk("ev_clr", 0, r[3:2]);
        m = n_clr;
        clr_cmd <= 1'b1;
        tick(1);
        clr_cmd <= 1'b0;
        tick(3);
        chk("clrwdt", m + 1, n_clr);
        wb(0, A_ST, 0, r);
        chk("pdf_clr", 0, r[0]);
        // each divide: leave slow clock with the oscillator off first
        for (int k = 0; k < 7; k++) begin
            wb(1, pmwc_pkg::ADDR_SCC, 32'h0000_00e0, r);
            waitc(1, 7, n);
            chk("slow_sel", pmwc_pkg::CKS_SLOW, csel);
            wb(1, pmwc_pkg::ADDR_FAST_OSC_CONTROL_REG, 0, r);
            wb(1, pmwc_pkg::ADDR_SCC, k << 5, r);
            tick(5);
            chk("hold_slow", 7, csel);
            wb(1, pmwc_pkg::ADDR_FAST_OSC_CONTROL_REG, 1, r);
            waitc(1, k, n);
            chk("fast_sel", k, csel);
            wb(0, pmwc_pkg::ADDR_FAST_OSC_CONTROL_REG, 0, r);
            chk("stable", 1, r[1]);
        end
        summarize();
    end
endmodule
`default_nettype wire
